/* qbs_pkg.sv */
// Shared constants for the burst-of-four static memory link.
// Assumes both ends are compiled after this package.
package qbs_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 18;
  localparam int BYTE_W = 9;
  localparam int NBYTE = 4;
  localparam int DATA_W = NBYTE * BYTE_W;
  localparam int BURST_LEN = 4;

  // ==========================================================
  // Link clock divider phases (controller clock cycles)
  localparam logic [1:0] PH_CMD = 2'h0;
  localparam logic [1:0] PH_SMP_FALL = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_SMP_RISE = 2'h3;
  localparam logic [1:0] PH_RESET = 2'h0;

  // ==========================================================
  // Beat indices inside one burst
  localparam logic [1:0] BEAT1 = 2'h0;
  localparam logic [1:0] BEAT2 = 2'h1;
  localparam logic [1:0] BEAT3 = 2'h2;
  localparam logic [1:0] BEAT4 = 2'h3;

  // ==========================================================
  // Write beat sequencer of the controller, Gray from WB_IDLE through WB_FOUR
  typedef enum logic [2:0] {
    WB_IDLE = 3'h0,
    WB_ONE = 3'h1,
    WB_TWO = 3'h3,
    WB_THREE = 3'h2,
    WB_FOUR = 3'h6
  } qbs_wbeat_t;

endpackage

/* qbs_link_if.sv */
// Link between the memory controller and the memory device.
// Assumes the bench connects one controller and one device to it.
`timescale 1ns/1ps
`default_nettype none
interface qbs_link_if #(
  parameter int ADDR_W = qbs_pkg::ADDR_W,
  parameter int DATA_W = qbs_pkg::DATA_W,
  parameter int NBYTE = qbs_pkg::NBYTE
);
  logic k;
  logic kn;
  logic rst_n;
  logic [ADDR_W-1:0] addr_in;
  logic rd_n;
  logic wr_n;
  logic [DATA_W-1:0] d;
  logic [NBYTE-1:0] byte_write_n;
  logic [DATA_W-1:0] q;
  logic echo_strobe_true;
  logic echo_strobe_comp;
  logic read_valid_flag;

  modport ctrl (
    output k, kn, rst_n, addr_in, rd_n, wr_n, d, byte_write_n,
    input q, echo_strobe_true, echo_strobe_comp, read_valid_flag
  );

  modport dev (
    input k, kn, rst_n, addr_in, rd_n, wr_n, d, byte_write_n,
    output q, echo_strobe_true, echo_strobe_comp, read_valid_flag
  );
endinterface
`default_nettype wire

/* qbs_sram_dev.sv */
// Memory device end: burst-of-four double data rate static memory.
// Assumes the link clocks k and kn come from the controller, kn the
// inverse of k, and that link reset is stable around rising edges of k.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Address and selects sampled on k rise
// RULE2: Read and write slots alternate per edge
// RULE3: Beats one and three taken on k
// RULE4: Beats two and four taken on kn
// RULE5: Byte enables travel per beat, masking bytes
// RULE6: First write beat one cycle after command
// RULE7: Write burst spans two clock cycles
// RULE8: Read beats one, three at edges three, four
// RULE9: Read beats two, four on kn three, four
// RULE10: Read burst spans two cycles on bus
// RULE11: Every burst is exactly four beats
// RULE12: Separate input and output data buses
// RULE13: Echo strobes travel with read data
// RULE14: Read valid marks data, aligned with strobes
// RULE15: Deselected edges ignore the address
// RULE16: Reads see bytes of pending writes
// RULE17: Controller drives active-low selects per slot
module qbs_sram_dev
  import qbs_pkg::*;
#(
  parameter int ADDR_W_P = ADDR_W
) (
  qbs_link_if.dev link
);

  localparam int DEPTH = (2 ** ADDR_W_P) * BURST_LEN;

  // ==========================================================
  // Storage
  logic [DATA_W-1:0] mem_q [0:DEPTH-1];

  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [NBYTE-1:0] bw_n
  );
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < NBYTE; i++) begin
      if (!bw_n[i]) begin
        r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Command slots
  logic phase_q;
  logic rd_take;
  logic wr_take;

  // RULE2: slot parity
  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // RULE1: selects on k rise
  // RULE15: no select, no address use
  // RULE17: command ignored outside its slot
  assign rd_take = link.rst_n && !phase_q && !link.rd_n;
  assign wr_take = link.rst_n && phase_q && !link.wr_n;

  // ==========================================================
  // Write path
  logic w1_q;
  logic w2_q;
  logic w3_q;
  logic [ADDR_W_P-1:0] wa1_q;
  logic [ADDR_W_P-1:0] wa2_q;
  logic [ADDR_W_P-1:0] wa3_q;
  logic [DATA_W-1:0] dfall_q;
  logic [NBYTE-1:0] bwfall_q;

  // RULE7: three-stage write tracking
  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      w1_q <= 1'b0;
      w2_q <= 1'b0;
      w3_q <= 1'b0;
    end else begin
      w1_q <= wr_take;
      w2_q <= w1_q;
      w3_q <= w2_q;
    end
  end

  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      wa1_q <= '0;
      wa2_q <= '0;
      wa3_q <= '0;
    end else begin
      if (wr_take) begin
        wa1_q <= link.addr_in[ADDR_W_P-1:0];
      end
      wa2_q <= wa1_q;
      wa3_q <= wa2_q;
    end
  end

  // RULE4: beats on kn capture
  // Captured every kn edge; only used when a write needs them
  always_ff @(posedge link.kn) begin
    if (!link.rst_n) begin
      dfall_q <= '0;
      bwfall_q <= '1;
    end else begin
      dfall_q <= link.d;
      bwfall_q <= link.byte_write_n;
    end
  end

  // Beats one and three are written as they land, two and four at the next k rise. A read fetches a beat
  // only at the k rise that starts its output cycle, which is after the matching beat of any
  // earlier write has landed, so no separate bypass is needed.
  // RULE16: coherent through early commit
  // RULE3: beats one, three from k
  // RULE5: per-beat byte masking
  // RULE6: data one cycle after command
  // RULE11: four beats per write
  always_ff @(posedge link.k) begin
    if (w1_q) begin
      mem_q[{wa1_q, BEAT1}] <= merge_bytes(mem_q[{wa1_q, BEAT1}], link.d, link.byte_write_n);
    end
    if (w2_q) begin
      mem_q[{wa2_q, BEAT2}] <= merge_bytes(mem_q[{wa2_q, BEAT2}], dfall_q, bwfall_q);
      mem_q[{wa2_q, BEAT3}] <= merge_bytes(mem_q[{wa2_q, BEAT3}], link.d, link.byte_write_n);
    end
    if (w3_q) begin
      mem_q[{wa3_q, BEAT4}] <= merge_bytes(mem_q[{wa3_q, BEAT4}], dfall_q, bwfall_q);
    end
  end

  // ==========================================================
  // Read path
  logic r1_q;
  logic r2_q;
  logic r3_q;
  logic [ADDR_W_P-1:0] ra1_q;
  logic [ADDR_W_P-1:0] ra2_q;
  logic [ADDR_W_P-1:0] ra3_q;
  logic [DATA_W-1:0] rise_q;
  logic rise_vld_q;
  logic [DATA_W-1:0] fall_pre_q;
  logic fall_pre_vld_q;
  logic [DATA_W-1:0] fall_q;
  logic fall_vld_q;

  // RULE8: latency pipeline
  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      r1_q <= 1'b0;
      r2_q <= 1'b0;
      r3_q <= 1'b0;
    end else begin
      r1_q <= rd_take;
      r2_q <= r1_q;
      r3_q <= r2_q;
    end
  end

  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      ra1_q <= '0;
      ra2_q <= '0;
      ra3_q <= '0;
    end else begin
      if (rd_take) begin
        ra1_q <= link.addr_in[ADDR_W_P-1:0];
      end
      ra2_q <= ra1_q;
      ra3_q <= ra2_q;
    end
  end

  // RULE8: beats one, three out
  // RULE10: two cycles of output
  // RULE11: four beats per read
  always_ff @(posedge link.k) begin
    if (!link.rst_n) begin
      rise_q <= '0;
      fall_pre_q <= '0;
      rise_vld_q <= 1'b0;
      fall_pre_vld_q <= 1'b0;
    end else begin
      if (r2_q) begin
        rise_q <= mem_q[{ra2_q, BEAT1}];
        fall_pre_q <= mem_q[{ra2_q, BEAT2}];
      end else if (r3_q) begin
        rise_q <= mem_q[{ra3_q, BEAT3}];
        fall_pre_q <= mem_q[{ra3_q, BEAT4}];
      end
      rise_vld_q <= r2_q | r3_q;
      fall_pre_vld_q <= r2_q | r3_q;
    end
  end

  // RULE9: beats two, four on kn
  always_ff @(posedge link.kn) begin
    if (!link.rst_n) begin
      fall_q <= '0;
      fall_vld_q <= 1'b0;
    end else begin
      fall_q <= fall_pre_q;
      fall_vld_q <= fall_pre_vld_q;
    end
  end

  // ==========================================================
  // Output pins
  // Double data rate: the clock level selects which flop shows,
  // so each half cycle carries a registered beat.
  // RULE12: dedicated output bus
  assign link.q = link.k ? rise_q : fall_q;
  // RULE14: valid follows the same select
  assign link.read_valid_flag = link.k ? rise_vld_q : fall_vld_q;
  // RULE13: free-running echo strobes
  assign link.echo_strobe_true = link.k;
  assign link.echo_strobe_comp = link.kn;

endmodule
`default_nettype wire

/* qbs_ctrl.sv */
// Memory controller end: turns user read and write bursts into link
// commands and collects read bursts.
// Assumes the device runs on the k and kn clocks made here.
`timescale 1ns/1ps
`default_nettype none
module qbs_ctrl
  import qbs_pkg::*;
#(
  parameter int ADDR_W_P = ADDR_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rd_req_in,
  input wire logic [ADDR_W_P-1:0] rd_addr_in,
  output logic rd_ready_out,
  input wire logic wr_req_in,
  input wire logic [ADDR_W_P-1:0] wr_addr_in,
  input wire logic [BURST_LEN*DATA_W-1:0] wr_data_in,
  input wire logic [BURST_LEN*NBYTE-1:0] wr_byte_n_in,
  output logic wr_ready_out,
  output logic [BURST_LEN*DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  qbs_link_if.ctrl link
);

  // ==========================================================
  // Link clock divider, k period four clk_in cycles
  logic [1:0] cnt_q;
  logic cmd_edge;
  logic fall_edge;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= PH_RESET;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign link.k = cnt_q[1];
  assign link.kn = ~cnt_q[1];
  // Outputs change one clk_in cycle, a quarter k period, before the edge that samples them
  assign cmd_edge = (cnt_q == PH_CMD);
  assign fall_edge = (cnt_q == PH_FALL);

  // ==========================================================
  // Slot tracking
  logic link_up_q;
  logic warm_q;
  logic slot_q;
  logic rd_go;
  logic wr_go;
  qbs_wbeat_t beat_q;

  assign link.rst_n = link_up_q;
  // RULE2: reads on even slots, writes on odd
  // RULE17: one command per slot
  assign rd_ready_out = cmd_edge && link_up_q && !slot_q;
  assign wr_ready_out = cmd_edge && link_up_q && slot_q && (beat_q == WB_IDLE || beat_q == WB_THREE);
  assign rd_go = rd_req_in && rd_ready_out;
  assign wr_go = wr_req_in && wr_ready_out;

  // k stands still while clk_in reset is held, and the device resets
  // only on k edges, so link reset is kept low across one k rise
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      warm_q <= 1'b0;
    end else if (cnt_q[1]) begin
      warm_q <= 1'b1;
    end
  end

  // First active k edge after reset is a read slot; left idle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_up_q <= 1'b0;
      slot_q <= 1'b0;
    end else if (cmd_edge && warm_q) begin
      link_up_q <= 1'b1;
      slot_q <= link_up_q ? ~slot_q : 1'b1;
    end
  end

  // RULE1: stable around k rise
  // RULE17: active-low selects
  logic rd_n_q;
  logic wr_n_q;
  logic [ADDR_W_P-1:0] addr_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      addr_q <= '0;
    end else if (cmd_edge) begin
      rd_n_q <= ~rd_go;
      wr_n_q <= ~wr_go;
      if (rd_go) begin
        addr_q <= rd_addr_in;
      end else if (wr_go) begin
        addr_q <= wr_addr_in;
      end
    end
  end

  assign link.rd_n = rd_n_q;
  assign link.wr_n = wr_n_q;
  assign link.addr_in = addr_q;

  // ==========================================================
  // Write beats: beat1 next k rise, then kn, k, kn
  logic [BURST_LEN*DATA_W-1:0] wdat_q;
  logic [BURST_LEN*NBYTE-1:0] wbe_q;
  logic [BURST_LEN*DATA_W-1:0] wnext_q;
  logic [BURST_LEN*NBYTE-1:0] wbe_next_q;
  logic wpend_q;
  logic [DATA_W-1:0] d_q;
  logic [NBYTE-1:0] bw_q;

  // RULE6: beat timing
  // RULE11: four beats, second buffer lets writes run back to back
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      beat_q <= WB_IDLE;
      wpend_q <= 1'b0;
      wdat_q <= '0;
      wbe_q <= '1;
      wnext_q <= '0;
      wbe_next_q <= '1;
      d_q <= '0;
      bw_q <= '1;
    end else begin
      if (wr_go && beat_q == WB_IDLE) begin
        wdat_q <= wr_data_in;
        wbe_q <= wr_byte_n_in;
        beat_q <= WB_ONE;
      end else if (wr_go) begin
        wnext_q <= wr_data_in;
        wbe_next_q <= wr_byte_n_in;
        wpend_q <= 1'b1;
        d_q <= wdat_q[2*DATA_W +: DATA_W];
        bw_q <= wbe_q[2*NBYTE +: NBYTE];
        beat_q <= WB_FOUR;
      end else if (cmd_edge && beat_q == WB_ONE) begin
        d_q <= wdat_q[0 +: DATA_W];
        bw_q <= wbe_q[0 +: NBYTE];
        beat_q <= WB_TWO;
      end else if (cmd_edge && beat_q == WB_THREE) begin
        d_q <= wdat_q[2*DATA_W +: DATA_W];
        bw_q <= wbe_q[2*NBYTE +: NBYTE];
        beat_q <= WB_FOUR;
      end else if (fall_edge && beat_q == WB_TWO) begin
        d_q <= wdat_q[DATA_W +: DATA_W];
        bw_q <= wbe_q[NBYTE +: NBYTE];
        beat_q <= WB_THREE;
      end else if (fall_edge && beat_q == WB_FOUR) begin
        d_q <= wdat_q[3*DATA_W +: DATA_W];
        bw_q <= wbe_q[3*NBYTE +: NBYTE];
        wpend_q <= 1'b0;
        if (wpend_q) begin
          wdat_q <= wnext_q;
          wbe_q <= wbe_next_q;
          beat_q <= WB_ONE;
        end else begin
          beat_q <= WB_IDLE;
        end
      end
    end
  end

  assign link.d = d_q;
  assign link.byte_write_n = bw_q;

  // ==========================================================
  // Read collection
  // k is derived from clk_in, so the return bus is sampled on the last clk_in edge of each k half, at a
  // fixed phase; a resynchroniser would only add latency here.
  logic take;
  logic [1:0] rcnt_q;
  logic [BURST_LEN*DATA_W-1:0] rsh_q;
  logic rd_valid_q;

  assign take = link.read_valid_flag &&
    ((cnt_q == PH_SMP_RISE && link.echo_strobe_true) || (cnt_q == PH_SMP_FALL && link.echo_strobe_comp));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rcnt_q <= '0;
      rsh_q <= '0;
      rd_valid_q <= 1'b0;
      rd_data_out <= '0;
    end else begin
      rd_valid_q <= 1'b0;
      if (take) begin
        rsh_q <= {link.q, rsh_q[BURST_LEN*DATA_W-1:DATA_W]};
        rcnt_q <= rcnt_q + 2'h1;
        if (rcnt_q == BEAT4) begin
          rd_valid_q <= 1'b1;
          rd_data_out <= {link.q, rsh_q[BURST_LEN*DATA_W-1:DATA_W]};
        end
      end
    end
  end

  assign rd_valid_out = rd_valid_q;

endmodule
`default_nettype wire

/* qbs_link_checker.sv */
// Concurrent checks on the link between controller and device.
// Assumes the bench wires it to the signals of the link interface.
`timescale 1ns/1ps
`default_nettype none
module qbs_link_checker (
  input wire logic k,
  input wire logic kn,
  input wire logic rst_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic echo_strobe_true,
  input wire logic echo_strobe_comp,
  input wire logic read_valid_flag
);
  // ==========================================================
  // Command slots and read timing, all on rising k
  default clocking cb @(posedge k); endclocking
  default disable iff (!rst_n);

  AST_RD_ALT: assert property (!rd_n |=> rd_n)
    else $error("read select on two adjacent edges");
  AST_WR_ALT: assert property (!wr_n |=> wr_n)
    else $error("write select on two adjacent edges");
  AST_ONE_CMD: assert property (!(!rd_n && !wr_n))
    else $error("read and write selected on one edge");
  AST_VALID_LAT: assert property (!rd_n |-> ##3 read_valid_flag ##1 read_valid_flag)
    else $error("read data not valid two cycles after command");
  AST_VALID_LEN: assert property (!rd_n ##2 rd_n |-> ##3 !read_valid_flag)
    else $error("read valid longer than two cycles");
  AST_VALID_CAUSE: assert property ($rose(read_valid_flag) |-> !$past(rd_n, 3))
    else $error("read valid without a read command");

  // ==========================================================
  // Echo strobes, checked on both halves of k
  AST_ECHO_HI: assert property (@(negedge k) disable iff (!rst_n) echo_strobe_true && !echo_strobe_comp)
    else $error("echo strobes out of step in high half");
  AST_ECHO_LO: assert property (@(posedge k) disable iff (!rst_n) !echo_strobe_true && echo_strobe_comp)
    else $error("echo strobes out of step in low half");
endmodule
`default_nettype wire

/* test_quad_burst4_sram_port.sv */
// Bench: controller and device joined by the link interface.
// Assumes the package, interface, both ends and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_quad_burst4_sram_port;
  import qbs_pkg::*;
  localparam int AW = 8;
  localparam int BW = BURST_LEN * DATA_W;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rd_req_in = 1'b0;
  logic wr_req_in = 1'b0;
  logic [AW-1:0] rd_addr_in = '0;
  logic [AW-1:0] wr_addr_in = '0;
  logic [BW-1:0] wr_data_in = '0;
  logic [15:0] wr_byte_n_in = 16'hffff;
  logic rd_ready_out;
  logic wr_ready_out;
  logic rd_valid_out;
  logic [BW-1:0] rd_data_out;
  logic [DATA_W-1:0] mem [0:4*(1<<AW)-1];
  logic [BW-1:0] exp_q [$];
  int fail_count = 0;
  int cmp_count = 0;
  int n_rd = 0;
  int n_got = 0;

  // ==========================================================
  // Design under test
  qbs_link_if #(.ADDR_W(AW)) lnk ();
  qbs_ctrl #(.ADDR_W_P(AW)) u_qbs_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .rd_req_in(rd_req_in),
    .rd_addr_in(rd_addr_in), .rd_ready_out(rd_ready_out), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .wr_byte_n_in(wr_byte_n_in), .wr_ready_out(wr_ready_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .link(lnk));
  qbs_sram_dev #(.ADDR_W_P(AW)) u_qbs_sram_dev (.link(lnk));
  qbs_link_checker u_qbs_link_checker (.k(lnk.k), .kn(lnk.kn), .rst_n(lnk.rst_n), .rd_n(lnk.rd_n),
    .wr_n(lnk.wr_n), .echo_strobe_true(lnk.echo_strobe_true), .echo_strobe_comp(lnk.echo_strobe_comp),
    .read_valid_flag(lnk.read_valid_flag));

  initial forever #5 clk_in = ~clk_in;

  // ==========================================================
  // Compare and closing tasks
  task automatic chk_data(input logic [BW-1:0] got, input logic [BW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: burst %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch at %0t: %0d bursts back, expected %0d", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // User-side bursts; a request is held until its slot comes
  task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] dat, input logic [15:0] bn);
    int i;
    @(negedge clk_in);
    wr_req_in = 1'b1;
    wr_addr_in = a;
    wr_data_in = dat;
    wr_byte_n_in = bn;
    for (i = 0; i < 40 && wr_ready_out !== 1'b1; i++) @(negedge clk_in);
    if (i >= 40) begin
      fail_count++;
      $display("mismatch at %0t: write slot never offered", $time);
    end
    @(posedge clk_in);
    for (int b = 0; b < 4; b++)
      for (int y = 0; y < NBYTE; y++)
        if (bn[b*NBYTE+y] == 1'b0) mem[{a, 2'(b)}][y*BYTE_W+:BYTE_W] = dat[b*DATA_W+y*BYTE_W+:BYTE_W];
    @(negedge clk_in);
    wr_req_in = 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a);
    logic [BW-1:0] e;
    int i;
    @(negedge clk_in);
    rd_req_in = 1'b1;
    rd_addr_in = a;
    for (i = 0; i < 40 && rd_ready_out !== 1'b1; i++) @(negedge clk_in);
    if (i >= 40) begin
      fail_count++;
      $display("mismatch at %0t: read slot never offered", $time);
    end
    @(posedge clk_in);
    for (int b = 0; b < 4; b++) e[b*DATA_W+:DATA_W] = mem[{a, 2'(b)}];
    exp_q.push_back(e);
    n_rd++;
    @(negedge clk_in);
    rd_req_in = 1'b0;
  endtask

  function automatic logic [BW-1:0] pat(input logic [7:0] s);
    for (int b = 0; b < 4; b++) pat[b*DATA_W+:DATA_W] = {s + 8'(b), 8'(b), 20'h5a3c1 ^ {12'h0, s}};
  endfunction

  // Mid-cycle look: the pulse lasts one cycle
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1) begin
      n_got++;
      if (exp_q.size() > 0) chk_data(rd_data_out, exp_q.pop_front());
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    for (int a = 0; a < 4; a++) wr(8'(a), pat(8'(a)), 16'h0000);
    wr(8'h01, pat(8'h40), 16'h0f5a);
    wr(8'h02, pat(8'h50), 16'hffff);
    for (int a = 0; a < 4; a++) rd(8'(a));
    wr(8'h03, pat(8'h66), 16'h00f0);
    rd(8'h03);
    fork
      wr(8'h00, pat(8'h77), 16'h0000);
      rd(8'h02);
    join
    fork
      wr(8'hff, pat(8'h88), 16'h0000);
      rd(8'h00);
    join
    rd(8'hff);
    repeat (30) @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(8'hff);
    rd(8'h01);
    repeat (30) @(negedge clk_in);
    chk_cnt(n_got, n_rd);
    summarize();
  end

  initial begin
    #50000;
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize();
  end
endmodule
`default_nettype wire
